// file: dv/mvbf_framer_assertions.sv
// Concurrent checks on the ports of the framer top.
// Assumes one clock and a synchronous, active-low reset.
`timescale 1ns/1ps

module mvbf_framer_chk #(
  parameter int BAUD_HZ = 921600,
  parameter int CLK_HZ = 50000000
) (
  // Clock and reset
  input wire logic i_sys_clk,
  input wire logic i_rst_n,
  // Watched ports
  input wire logic i_val_valid,
  input wire logic o_val_ready,
  input wire logic i_meas_tick,
  input wire logic o_txd,
  input wire logic o_runtime_err,
  input wire logic o_busy
);
  localparam int BIT = CLK_HZ / BAUD_HZ;
  logic [15:0] run; // Edges seen at the present line level

  // ==========================================================
  // Helper: length of the present line level, for bit timing
  always_ff @(posedge i_sys_clk) begin
    if (!i_rst_n) begin
      run <= 16'h0;
    end else begin
      run <= $changed(o_txd) ? 16'h1 : run + 16'h1;
    end
  end

  // ==========================================================
  // Checks
  default clocking cb @(posedge i_sys_clk); endclocking
  default disable iff (!i_rst_n);
  // A value taken while the line rests
  sequence s_take_idle;
    i_val_valid && o_val_ready && !o_busy && o_txd;
  endsequence
  // Start bit follows through buffer, sequencer and shifter
  sequence s_start;
    ##[2:4] !o_txd;
  endsequence

  chk_reset_idle: assert property (
    $rose(i_rst_n) |-> o_txd && !o_busy && !o_runtime_err && o_val_ready) else $error("outputs not idle after reset");
  chk_err_width: assert property (
    o_runtime_err |=> !o_runtime_err) else $error("error pulse wider than one cycle");
  chk_err_cause: assert property (
    o_runtime_err |-> $past(i_meas_tick) || ($past(i_val_valid) && $past(o_val_ready))) else $error("error without cause");
  chk_late_tick: assert property (
    i_meas_tick && !o_val_ready |=> o_runtime_err) else $error("tick with full buffer not flagged");
  chk_idle_high: assert property (
    !o_busy |-> o_txd) else $error("line low while idle");
  chk_bit_time: assert property (
    $rose(o_txd) |-> (int'(run) % BIT) == 0) else $error("low run not whole bit times");
  chk_first_start: assert property (
    s_take_idle |-> s_start) else $error("start bit late after take");
  chk_full_busy: assert property (
    !o_val_ready |-> o_busy) else $error("buffer full but line idle");
endmodule

bind mvbf_framer mvbf_framer_chk #(.BAUD_HZ(BAUD_HZ), .CLK_HZ(CLK_HZ)) u_mvbf_framer_chk (
  .i_sys_clk(i_sys_clk),
  .i_rst_n(i_rst_n),
  .i_val_valid(i_val_valid),
  .o_val_ready(o_val_ready),
  .i_meas_tick(i_meas_tick),
  .o_txd(o_txd),
  .o_runtime_err(o_runtime_err),
  .o_busy(o_busy)
);

// file: dv/mvbf_rx_model.sv
// Serial receiver model: 8N1 byte capture and flag-driven word rebuild.
// Assumes the line idles high and bits last BIT clocks.
`timescale 1ns/1ps

module mvbf_rx_model #(
  parameter int BIT = 54
) (
  // Clock and line
  input wire logic i_sys_clk,
  input wire logic i_rxd,
  // Captured bytes and words
  output logic [7:0] o_byte,
  output logic o_stb,
  output logic o_stop_ok,
  output logic [18:0] o_word, // Opens block, then value
  output logic o_word_stb
);
  logic [1:0] stage; // Sextets gathered so far
  logic [17:0] acc;

  initial begin
    {o_byte, o_stb, o_stop_ok, o_word, o_word_stb, stage, acc} = '0;
  end

  // ==========================================================
  // Sample mid-bit; a start glitch shorter than half a bit is ignored
  always begin
    @(negedge i_rxd);
    repeat (BIT / 2) @(posedge i_sys_clk);
    if (!i_rxd) begin
      for (int i = 0; i < 8; i++) begin
        repeat (BIT) @(posedge i_sys_clk);
        o_byte[i] = i_rxd;
      end
      repeat (BIT) @(posedge i_sys_clk);
      o_stop_ok <= i_rxd;
      o_stb <= 1'b1;
      case (o_byte[7:6])
        2'h0: begin
          acc[5:0] = o_byte[5:0];
          stage = 2'h1;
        end
        2'h1: begin
          acc[11:6] = o_byte[5:0];
          stage = (stage == 2'h1) ? 2'h2 : 2'h0;
        end
        default: begin
          // Out-of-order pieces are dropped, never emitted
          if (stage == 2'h2) begin
            o_word <= {~o_byte[6], o_byte[5:0], acc[11:0]};
            o_word_stb <= 1'b1;
          end
          stage = 2'h0;
        end
      endcase
      @(posedge i_sys_clk);
      o_stb <= 1'b0;
      o_word_stb <= 1'b0;
    end
  end
endmodule

// file: dv/test_measurement_value_byte_framer.sv
// Self-checking bench of the framer against a serial receiver model.
// Assumes the framer runs at its default line rate.
`timescale 1ns/1ps
`include "mvbf_params.svh"

module test_measurement_value_byte_framer;
  localparam int BIT = `MVBF_CLK_HZ / `MVBF_BAUD_HZ;
  logic i_sys_clk, i_rst_n, i_val_valid, i_val_first, i_val_last, i_meas_tick, i_info_query;
  logic [`MVBF_VALUE_W-1:0] i_val_data;
  logic [7:0] i_out_select, rx_byte, bq[$];
  logic [18:0] rx_word, wq[$];
  logic o_val_ready, o_txd, o_runtime_err, o_busy, rx_stb, stop_ok, word_stb;
  logic [31:0] seed;
  int num_errors, num_checks;
  int rt_exp, rt_seen; // Runtime error pulses owed and seen

  // ==========================================================
  // Clock, design and receiver
  initial i_sys_clk = 1'b0;
  always #10 i_sys_clk = ~i_sys_clk;

  mvbf_framer u_mvbf_framer (.i_sys_clk(i_sys_clk), .i_rst_n(i_rst_n), .i_val_valid(i_val_valid),
    .i_val_data(i_val_data), .i_val_first(i_val_first), .i_val_last(i_val_last), .o_val_ready(o_val_ready),
    .i_meas_tick(i_meas_tick), .i_info_query(i_info_query), .i_out_select(i_out_select), .o_txd(o_txd),
    .o_runtime_err(o_runtime_err), .o_busy(o_busy));
  mvbf_rx_model #(.BIT(BIT)) u_mvbf_rx_model (.i_sys_clk(i_sys_clk), .i_rxd(o_txd), .o_byte(rx_byte),
    .o_stb(rx_stb), .o_stop_ok(stop_ok), .o_word(rx_word), .o_word_stb(word_stb));

  // ==========================================================
  // Helpers
  function logic [31:0] xs();
    seed ^= seed << 13;
    seed ^= seed >> 17;
    seed ^= seed << 5;
    return seed;
  endfunction

  // Uppercase hex digit of the selection answer
  function logic [7:0] hexc(input logic [3:0] n);
    return (n < 4'ha) ? `MVBF_CHAR_ZERO + n : `MVBF_CHAR_ALPHA + n;
  endfunction

  task check(input string n, input logic [18:0] e, input logic [18:0] g);
    num_checks++;
    if (g !== e) begin
      num_errors++;
      $display("unexpected %s: expected %h, seen %h", n, e, g);
    end
  endtask

  task test_done();
    $display("checks %0d, errors %0d", num_checks, num_errors);
    if (num_errors == 0 && num_checks > 0) begin
      $display("No errors found");
    end else begin
      $display("Errors were found");
    end
    $finish;
  endtask

  task push_answer(input logic [7:0] s);
    bq.push_back(`MVBF_CHAR_INFO);
    bq.push_back(hexc(s[7:4]));
    bq.push_back(hexc(s[3:0]));
    bq.push_back(`MVBF_CHAR_CR);
    bq.push_back(`MVBF_CHAR_LF);
  endtask

  // Offer one value, note its bytes; a single tick pulse when the buffer
  // first refuses, since the tick is a one-cycle event, not a level
  task put(input logic [17:0] v, input logic f, input logic l, input logic q, input logic [1:0] hf);
    int n;
    @(posedge i_sys_clk);
    i_val_valid <= 1'b1;
    i_val_data <= v;
    i_val_first <= f;
    i_val_last <= l;
    i_info_query <= q;
    bq.push_back({`MVBF_FLAG_LOW, v[5:0]});
    bq.push_back({`MVBF_FLAG_MID, v[11:6]});
    bq.push_back({hf, v[17:12]});
    wq.push_back({hf == `MVBF_FLAG_HIGH_FIRST, v});
    n = 0;
    do begin
      @(posedge i_sys_clk);
      i_info_query <= 1'b0;
      i_meas_tick <= !o_val_ready && n == 0;
      rt_exp += (!o_val_ready && n == 0);
      n++;
    end while (!o_val_ready && n < 5000);
    if (n >= 5000) begin
      num_errors++;
      test_done();
    end
    i_val_valid <= 1'b0;
  endtask

  task query();
    logic [7:0] s;
    s = 8'(xs());
    @(posedge i_sys_clk);
    i_out_select <= s;
    i_info_query <= 1'b1;
    push_answer(s);
    @(posedge i_sys_clk);
    i_info_query <= 1'b0;
  endtask

  // Wait until every noted byte has arrived and the line rests
  task drain();
    int n;
    n = 0;
    while ((o_busy || bq.size() != 0) && n < 20000) begin
      @(posedge i_sys_clk);
      n++;
    end
    if (n >= 20000) begin
      num_errors++;
      test_done();
    end
  endtask

  // ==========================================================
  // Monitor: oldest note against each received byte and word
  always @(posedge i_sys_clk) begin
    if (rx_stb) begin
      check("stop bit", 19'h1, {18'h0, stop_ok});
      check("line byte", {11'h0, (bq.size() != 0) ? bq.pop_front() : 8'hxx}, {11'h0, rx_byte});
    end
    if (word_stb) begin
      check("word", (wq.size() != 0) ? wq.pop_front() : 19'hxxxxx, rx_word);
    end
    // Every error pulse is counted, so a stray one shows in the final count
    if (o_runtime_err) begin
      rt_seen++;
    end
  end

  // ==========================================================
  // Main sequence
  initial begin
    seed = 32'h1967;
    num_errors = 0;
    num_checks = 0;
    rt_exp = 0;
    rt_seen = 0;
    {i_rst_n, i_val_valid, i_val_data, i_val_first, i_val_last, i_meas_tick, i_info_query} = '0;
    i_out_select = 8'(xs());
    repeat (2) @(posedge i_sys_clk);
    i_rst_n <= 1'b1;
    // Block of four: buffer fills, query waits for the block end
    put(18'h3ffff, 1'b1, 1'b0, 1'b0, `MVBF_FLAG_HIGH_FIRST);
    put(18'(xs()), 1'b0, 1'b0, 1'b1, `MVBF_FLAG_HIGH_NEXT);
    put(18'h0, 1'b0, 1'b0, 1'b0, `MVBF_FLAG_HIGH_NEXT);
    put(18'(xs()), 1'b0, 1'b1, 1'b0, `MVBF_FLAG_HIGH_NEXT);
    push_answer(i_out_select);
    drain();
    // Values without an open block start one
    put(18'(xs()), 1'b0, 1'b1, 1'b0, `MVBF_FLAG_HIGH_FIRST);
    put(18'(xs()), 1'b0, 1'b0, 1'b0, `MVBF_FLAG_HIGH_FIRST);
    put(18'(xs()), 1'b0, 1'b1, 1'b0, `MVBF_FLAG_HIGH_NEXT);
    drain();
    // Query on an idle line
    query();
    drain();
    check("runtime errors", 19'(rt_exp), 19'(rt_seen));
    check("words left", 19'h0, 19'(wq.size()));
    test_done();
  end
endmodule

// file: inc/mvbf_params.svh
// Constants of the measurement value byte framer: offsets, field positions,
// flag codes and timing figures.
// Assumes it is included by its bare name from files that need the numbers.
`ifndef MVBF_PARAMS_SVH
`define MVBF_PARAMS_SVH

// ==========================================================
// Clock and line rates
`define MVBF_CLK_HZ 50000000
`define MVBF_BAUD_HZ 921600
`define MVBF_BAUD_MAX_HZ 1000000

// ==========================================================
// Value layout: three sextets of an 18-bit word
`define MVBF_VALUE_W 18
`define MVBF_SEXTET_W 6
`define MVBF_LOW_LSB 0
`define MVBF_MID_LSB 6
`define MVBF_HIGH_LSB 12

// ==========================================================
// Flag codes in the two top bits of each value byte
`define MVBF_FLAG_LOW 2'h0
`define MVBF_FLAG_MID 2'h1
`define MVBF_FLAG_HIGH_FIRST 2'h2
`define MVBF_FLAG_HIGH_NEXT 2'h3

// ==========================================================
// Block and character framing
`define MVBF_BLOCK_MAX 32
`define MVBF_UART_BITS 10
`define MVBF_SELECT_W 8
`define MVBF_INFO_LEN 5
`define MVBF_CHAR_INFO 8'h49
`define MVBF_CHAR_CR 8'h0d
`define MVBF_CHAR_LF 8'h0a
`define MVBF_CHAR_ZERO 8'h30
`define MVBF_CHAR_ALPHA 8'h37

`endif

// file: inc/mvbf_pkg.sv
// Types shared by the framer and its buffer.
// Assumes mvbf_params.svh is on the include path.
`include "mvbf_params.svh"

package mvbf_pkg;
  // ==========================================================
  // Types
  typedef logic [7:0] mvbf_byte_t;
  typedef logic [`MVBF_VALUE_W-1:0] mvbf_value_t;

  // Transmit sequencer states
  typedef enum logic [1:0] {
    MVBF_IDLE,
    MVBF_VALUE,
    MVBF_INFO
  } mvbf_state_e;
endpackage

// file: inc/mvbf_stream_if.sv
// Value stream carrier between the framer top and its two-entry buffer.
// Assumes both ends run on the same clock.
`timescale 1ns/1ps

interface mvbf_stream_if #(
  parameter int W = 18
);
  logic valid;   // Word offered
  logic ready;   // Word accepted when both high
  logic first;   // Word opens a block
  logic last;    // Word closes a block
  logic [W-1:0] data;

  // ==========================================================
  // Ends
  modport src (output valid, output first, output last, output data, input ready);
  modport snk (input valid, input first, input last, input data, output ready);
endinterface

// file: verilog/mvbf_framer.sv
// Measurement value byte framer: turns 18-bit output values into flagged
// three-byte groups on an 8N1 serial line, and answers the output info query.
// Assumes values, query and measurement ticks come from logic on i_sys_clk.
//
// Behaviour
// [R1] Three bytes, flags 00/01/high, six bits each
// [R2] High flag 10 first value, 11 after
// [R3] Send low, then middle, then high byte
// [R4] Block values go out back to back
// [R5] Late or overlong block raises runtime error
// [R6] Values keep streaming while queries are answered
// [R7] Receiver strips flags, rebuilds 16/18-bit word
// [R8] Receiver decodes top two bits specially
// [R9] Full 18 bits carry value or error
// [R10] Query answered with selection; receiver asks
// [R11] Every byte framed 8N1
// [R12] Up to 1 MBaud, default 921.6 kBaud
// [R13] Values binary, command answers ASCII
// [R14] Receiver resyncs on flag order
`timescale 1ns/1ps
`include "mvbf_params.svh"

module mvbf_framer import mvbf_pkg::*; #(
  parameter int BAUD_HZ = `MVBF_BAUD_HZ,
  parameter int CLK_HZ = `MVBF_CLK_HZ
) (
  // Clock and reset
  input wire logic i_sys_clk,
  input wire logic i_rst_n,
  // Value stream in
  input wire logic i_val_valid,
  input wire logic [`MVBF_VALUE_W-1:0] i_val_data,
  input wire logic i_val_first,
  input wire logic i_val_last,
  output logic o_val_ready,
  // Measurement timing and command side
  input wire logic i_meas_tick,
  input wire logic i_info_query,
  input wire logic [`MVBF_SELECT_W-1:0] i_out_select,
  // Serial line and status
  output logic o_txd,
  output logic o_runtime_err,
  output logic o_busy
);
  // ==========================================================
  // Timing: one bit time in clock cycles, rounded down
  localparam int BIT_CYCLES = CLK_HZ / BAUD_HZ;
  localparam logic [15:0] BIT_LAST = 16'(BIT_CYCLES - 1);

  // Refuse rates the divider or the line cannot serve
  generate
    if (BAUD_HZ > `MVBF_BAUD_MAX_HZ || BAUD_HZ < 1 || BIT_CYCLES < 1 || BIT_CYCLES > 65536) begin : g_bad_rate
      $error("mvbf_framer baud rate out of range");
    end
  endgenerate

  // ==========================================================
  // Helpers

  // Flag pair above a sextet of payload
  function automatic mvbf_byte_t mvbf_pack(input logic [1:0] flag, input logic [5:0] sextet);
    mvbf_pack = {flag, sextet};
  endfunction

  // ASCII hex digit of a nibble
  function automatic mvbf_byte_t mvbf_hex(input logic [3:0] nib);
    if (nib < 4'ha) begin
      mvbf_hex = `MVBF_CHAR_ZERO + {4'h0, nib};
    end else begin
      mvbf_hex = `MVBF_CHAR_ALPHA + {4'h0, nib};
    end
  endfunction

  // ==========================================================
  // Input buffer: a receiver-side stall loses no value
  mvbf_stream_if #(.W(`MVBF_VALUE_W)) in_s ();
  mvbf_stream_if #(.W(`MVBF_VALUE_W)) out_s ();

  assign in_s.valid = i_val_valid;
  assign in_s.data = i_val_data;
  assign in_s.first = i_val_first;
  assign in_s.last = i_val_last;
  assign o_val_ready = in_s.ready;

  mvbf_pair_buf #(.W(`MVBF_VALUE_W)) u_buf (
    .i_sys_clk(i_sys_clk),
    .i_rst_n(i_rst_n),
    .fill(in_s),
    .drain(out_s)
  );

  // ==========================================================
  // State
  mvbf_state_e state;          // Sequencer state
  mvbf_value_t cur_value;      // Value being sent
  logic cur_first;             // Value opens its block
  logic cur_last;              // Value closes its block
  logic [2:0] byte_idx;        // Byte within the value or answer
  logic in_block;              // A block has started and not closed
  logic [5:0] block_cnt;       // Values sent in the open block
  logic query_pend;            // Query waiting for a gap between blocks
  logic [`MVBF_SELECT_W-1:0] sel_snap; // Selection captured for the answer

  // Serial shifter
  logic [`MVBF_UART_BITS-1:0] tx_shift;
  logic [3:0] tx_bits;         // Bits left in the frame
  logic [15:0] baud_cnt;       // Divider within one bit
  logic tx_busy;
  logic bit_tick;              // One-cycle enable at each bit end
  logic tx_load;               // Start a frame this cycle
  mvbf_byte_t tx_byte;         // Byte to frame

  // Sequencer decisions
  logic take_value;
  logic start_info;
  logic value_first;
  logic overlong;

  // ==========================================================
  // Decisions for the idle sequencer
  // A value is taken whenever one waits and no query is pending outside a block;
  // the query answer slips in only outside a block so a block is never split.
  assign value_first = out_s.first || !in_block;
  assign overlong = in_block && !out_s.first && (block_cnt == 6'(`MVBF_BLOCK_MAX));
  assign take_value = (state == MVBF_IDLE) && out_s.valid && !(query_pend && !in_block); // R4 R6
  assign start_info = (state == MVBF_IDLE) && query_pend && !in_block; // R10
  assign out_s.ready = take_value;

  // Next byte for the line, only meaningful while a frame is loaded
  always_comb begin
    tx_byte = 8'h00;
    unique case (state)
      MVBF_VALUE: begin
        // Low, middle, high in that order
        unique case (byte_idx)
          3'h0: tx_byte = mvbf_pack(`MVBF_FLAG_LOW, cur_value[`MVBF_LOW_LSB +: `MVBF_SEXTET_W]); // R1 R3
          3'h1: tx_byte = mvbf_pack(`MVBF_FLAG_MID, cur_value[`MVBF_MID_LSB +: `MVBF_SEXTET_W]); // R1 R3
          default: begin
            if (cur_first) begin
              tx_byte = mvbf_pack(`MVBF_FLAG_HIGH_FIRST, cur_value[`MVBF_HIGH_LSB +: `MVBF_SEXTET_W]); // R2 R9
            end else begin
              tx_byte = mvbf_pack(`MVBF_FLAG_HIGH_NEXT, cur_value[`MVBF_HIGH_LSB +: `MVBF_SEXTET_W]); // R2 R9
            end
          end
        endcase
      end
      MVBF_INFO: begin
        // ASCII answer: marker, two hex digits of the selection, CR, LF
        unique case (byte_idx)
          3'h0: tx_byte = `MVBF_CHAR_INFO; // R13
          3'h1: tx_byte = mvbf_hex(sel_snap[7:4]); // R10
          3'h2: tx_byte = mvbf_hex(sel_snap[3:0]); // R10
          3'h3: tx_byte = `MVBF_CHAR_CR;
          default: tx_byte = `MVBF_CHAR_LF;
        endcase
      end
      default: tx_byte = 8'h00;
    endcase
  end

  // A frame starts as soon as the shifter is free and a byte is owed
  assign tx_load = !tx_busy && (state != MVBF_IDLE);

  // ==========================================================
  // Sequencer: value and answer byte stepping
  always_ff @(posedge i_sys_clk) begin
    if (!i_rst_n) begin
      state <= MVBF_IDLE;
      byte_idx <= 3'h0;
      cur_value <= '0;
      cur_first <= 1'b0;
      cur_last <= 1'b0;
      sel_snap <= '0;
    end else begin
      unique case (state)
        MVBF_IDLE: begin
          if (start_info) begin
            // Selection is frozen so the two digits agree
            sel_snap <= i_out_select;
            byte_idx <= 3'h0;
            state <= MVBF_INFO;
          end else if (take_value) begin
            cur_value <= out_s.data;
            cur_first <= value_first || overlong; // R2
            cur_last <= out_s.last;
            byte_idx <= 3'h0;
            state <= MVBF_VALUE;
          end
        end
        MVBF_VALUE: begin
          if (tx_load) begin
            if (byte_idx == 3'h2) begin
              state <= MVBF_IDLE;
            end else begin
              byte_idx <= byte_idx + 3'h1; // R3
            end
          end
        end
        MVBF_INFO: begin
          if (tx_load) begin
            if (byte_idx == 3'(`MVBF_INFO_LEN - 1)) begin
              state <= MVBF_IDLE;
            end else begin
              byte_idx <= byte_idx + 3'h1;
            end
          end
        end
      endcase
    end
  end

  // ==========================================================
  // Block tracking: count values and know when a block is open
  always_ff @(posedge i_sys_clk) begin
    if (!i_rst_n) begin
      in_block <= 1'b0;
      block_cnt <= 6'h0;
    end else if (take_value) begin
      // A block closes on its last value; the next value reopens one
      in_block <= !out_s.last;
      if (value_first || overlong) begin
        block_cnt <= 6'h1;
      end else begin
        block_cnt <= block_cnt + 6'h1;
      end
    end
  end

  // ==========================================================
  // Query latch: a new query in the clearing cycle is kept
  always_ff @(posedge i_sys_clk) begin
    if (!i_rst_n) begin
      query_pend <= 1'b0;
    end else if (i_info_query) begin
      query_pend <= 1'b1; // R10
    end else if (start_info) begin
      query_pend <= 1'b0;
    end
  end

  // ==========================================================
  // Runtime error: the next measurement arrived while the previous
  // block was still open or waiting, or a block ran past its limit
  always_ff @(posedge i_sys_clk) begin
    if (!i_rst_n) begin
      o_runtime_err <= 1'b0;
    end else begin
      o_runtime_err <= (i_meas_tick && (in_block || out_s.valid)) || (take_value && overlong); // R5
    end
  end

  // ==========================================================
  // Bit-rate divider: restarts at each frame so the start bit is full
  always_ff @(posedge i_sys_clk) begin
    if (!i_rst_n) begin
      baud_cnt <= 16'h0;
    end else if (tx_load || !tx_busy || bit_tick) begin
      baud_cnt <= 16'h0;
    end else begin
      baud_cnt <= baud_cnt + 16'h1; // R12
    end
  end

  assign bit_tick = tx_busy && (baud_cnt == BIT_LAST);

  // ==========================================================
  // Serial shifter: start bit, eight data bits LSB first, one stop bit
  always_ff @(posedge i_sys_clk) begin
    if (!i_rst_n) begin
      tx_shift <= '1;
      tx_bits <= 4'h0;
      tx_busy <= 1'b0;
    end else if (tx_load) begin
      tx_shift <= {1'b1, tx_byte, 1'b0}; // R11
      tx_bits <= 4'(`MVBF_UART_BITS);
      tx_busy <= 1'b1;
    end else if (bit_tick) begin
      tx_shift <= {1'b1, tx_shift[`MVBF_UART_BITS-1:1]};
      tx_bits <= tx_bits - 4'h1;
      if (tx_bits == 4'h1) begin
        tx_busy <= 1'b0;
      end
    end
  end

  // Line level from a flop; idles high between frames
  always_ff @(posedge i_sys_clk) begin
    if (!i_rst_n) begin
      o_txd <= 1'b1;
    end else if (tx_load) begin
      o_txd <= 1'b0;
    end else if (bit_tick) begin
      o_txd <= (tx_bits == 4'h1) ? 1'b1 : tx_shift[1];
    end
  end

  // Busy while anything is owed to the line
  always_ff @(posedge i_sys_clk) begin
    if (!i_rst_n) begin
      o_busy <= 1'b0;
    end else begin
      o_busy <= tx_busy || (state != MVBF_IDLE) || out_s.valid || query_pend;
    end
  end

  // Unused on purpose: the close of a value is tracked at take time
  logic unused_last;
  assign unused_last = cur_last;
endmodule

// file: verilog/mvbf_pair_buf.sv
// Two-entry buffer for framed values, with valid and ready on both sides.
// Assumes a single clock and a synchronous, active-low reset.
`timescale 1ns/1ps

module mvbf_pair_buf import mvbf_pkg::*; #(
  parameter int W = 18
) (
  // Clock and reset
  input wire logic i_sys_clk,
  input wire logic i_rst_n,
  // Filling and draining sides
  mvbf_stream_if.snk fill,
  mvbf_stream_if.src drain
);
  // ==========================================================
  // Storage: data plus first and last marks, in flip-flops
  logic [W+1:0] mem [2];
  logic wr_ptr;        // Next slot to write
  logic rd_ptr;        // Slot at the head
  logic [1:0] count;   // Words held, 0 to 2
  logic push;
  logic pop;

  generate
    if (W < 1) begin : g_bad_width
      $error("mvbf_pair_buf needs a positive width");
    end
  endgenerate

  // Handshakes are combinational; full and empty come from the count
  assign fill.ready = (count != 2'h2);
  assign drain.valid = (count != 2'h0);
  assign push = fill.valid && fill.ready;
  assign pop = drain.valid && drain.ready;
  assign drain.data = mem[rd_ptr][W-1:0];
  assign drain.first = mem[rd_ptr][W];
  assign drain.last = mem[rd_ptr][W+1];

  // Write slot; storage needs no reset since count guards it
  always_ff @(posedge i_sys_clk) begin
    if (push) begin
      mem[wr_ptr] <= {fill.last, fill.first, fill.data};
    end
  end

  // Pointers and occupancy
  always_ff @(posedge i_sys_clk) begin
    if (!i_rst_n) begin
      wr_ptr <= 1'b0;
      rd_ptr <= 1'b0;
      count <= 2'h0;
    end else begin
      if (push) begin
        wr_ptr <= ~wr_ptr;
      end
      if (pop) begin
        rd_ptr <= ~rd_ptr;
      end
      // Simultaneous push and pop leave the count alone
      if (push && !pop) begin
        count <= count + 2'h1;
      end else if (pop && !push) begin
        count <= count - 2'h1;
      end
    end
  end
endmodule
